// ---- design/dtr_recorder.sv ----
// Diagnostic trace recorder: eight channels sampled into trace buffers on firing ticks.
// Assumes sig_data answers sig_addr combinationally on the same clock, and that
// firing_tick and fault_event are one-cycle pulses from logic on this clock.
//
// Notes on behaviour
// - There are eight trace buffers, one per channel, of 128 entries each.
// - A read-only valid line count from 0 to 128 says how many entries hold data.
// - Buffer read-back uses an index of 00 to 99; entries above it read as zero.
// - Buffer words read as raw hex or as tenths of a percent, 16384 being 100 percent.
// - The trigger index holds the buffer entry of the record on which the trigger hit.
// - Nine channel selects exist; entry zero is reserved, 1 to 8 pick signals 0 to 399.
// - The live values of channels one and two drive the two monitor outputs.
// - The trigger source select picks the signal compared for the trigger.
// - Trigger type 0 is below, 1 equal, 2 above threshold, 3 any fault.
// - The threshold is a signed value of -204.8 to 204.7 percent in 0.1 percent steps.
// - All channels are sampled once every N firing ticks, N being 1 to 99.
// - A firing tick marks one sixth of the supply period and paces sampling.
// - Reset gives interval 1, type 0, threshold 0, source 0 and all selects 0.
// - After the trigger, recording runs for 1 to 999 more record cycles.
// - Writing arm 1 starts a recording; the device clears arm when it stops.
module dtr_recorder #(
	parameter int NUM_CH     = 8,
	parameter int DEPTH      = 128,
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        firing_tick,
	input  wire logic        fault_event,
	output logic      [8:0]  sig_addr,
	input  wire logic [15:0] sig_data,
	output logic      [15:0] monitor_display_one,
	output logic      [15:0] monitor_display_two
);
	`include "dtr_regs.svh"

	localparam int IW  = $clog2(DEPTH);
	localparam int PW  = 3 + IW + 16;

	if (NUM_CH != 8 || DEPTH < 2 || DEPTH > 128 || (1 << IW) != DEPTH) begin : bad_cfg
		$error("dtr_recorder: eight channels and a power-of-two depth up to 128 needed");
	end

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [8:0]  trig_src_reg;
	logic [1:0]  trig_type_reg;
	logic [11:0] thresh_reg;
	logic [6:0]  interval_reg;
	logic [9:0]  post_reg;
	logic        format_reg;
	logic [8:0]  chsel_reg [1:8];
	logic        arm_wr;
	logic        chsel_hit;
	logic [3:0]  chsel_idx;

	assign arm_wr    = reg_wr && reg_addr == `DTR_A_ARM;
	assign chsel_hit = reg_addr >= `DTR_A_CHSEL && reg_addr <= `DTR_A_CHSEL_LAST;
	assign chsel_idx = 4'(reg_addr - `DTR_A_CHSEL);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_src_reg  <= `DTR_RST_SIG;
			trig_type_reg <= `DTR_RST_TYPE;
			thresh_reg    <= `DTR_RST_THRESH;
			interval_reg  <= `DTR_RST_INTERVAL;
			post_reg      <= `DTR_RST_POST;
			format_reg    <= `DTR_RST_FORMAT;
			for (int i = 1; i <= 8; i++) begin
				chsel_reg[i] <= `DTR_RST_SIG;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`DTR_A_TRIG_SRC:  trig_src_reg  <= reg_wdata[8:0];
				`DTR_A_TRIG_TYPE: trig_type_reg <= reg_wdata[1:0];
				`DTR_A_THRESH:    thresh_reg    <= reg_wdata[11:0];
				`DTR_A_FORMAT:    format_reg    <= reg_wdata[0];
				// Out-of-range counts are clamped so the divider never sees zero
				`DTR_A_INTERVAL: begin
					if (reg_wdata == 16'h0000) begin
						interval_reg <= 7'h01;
					end else if (reg_wdata > 16'(`DTR_MAX_INTERVAL)) begin
						interval_reg <= `DTR_MAX_INTERVAL;
					end else begin
						interval_reg <= reg_wdata[6:0];
					end
				end
				`DTR_A_POST: begin
					if (reg_wdata == 16'h0000) begin
						post_reg <= 10'h001;
					end else if (reg_wdata > 16'(`DTR_MAX_POST)) begin
						post_reg <= `DTR_MAX_POST;
					end else begin
						post_reg <= reg_wdata[9:0];
					end
				end
				default: begin
					if (chsel_hit && chsel_idx != 4'h0) begin
						chsel_reg[chsel_idx] <= reg_wdata[8:0];
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Sample sweep
	// ----------------------------------------
	dtr_pkg::dtr_state_e state_reg;
	logic [6:0]  tick_cnt_reg;
	logic        sweep_reg;
	logic        rec_sweep_reg;
	logic [3:0]  step_reg;
	logic [15:0] trig_val_reg;
	logic        push_ready;
	logic        push_valid;
	logic        advance;
	logic        sweep_start;
	logic        sweep_end;
	logic        rec_end;
	logic        record_en;
	logic [IW-1:0] wp_reg;

	// Ticks arriving mid-sweep are dropped; a sweep lasts about ten clocks
	assign sweep_start = !sweep_reg && firing_tick;
	assign record_en   = tick_cnt_reg >= interval_reg - 7'h01;
	assign advance     = sweep_reg && (!rec_sweep_reg || step_reg == 4'h0 || push_ready);
	assign push_valid  = sweep_reg && rec_sweep_reg && step_reg != 4'h0;
	assign sweep_end   = advance && step_reg == 4'(NUM_CH);
	assign rec_end     = sweep_end && rec_sweep_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= 7'h00;
		end else if (arm_wr || (reg_wr && reg_addr == `DTR_A_INTERVAL)) begin
			// A shorter interval written mid-count must not leave the divider above it
			tick_cnt_reg <= 7'h00;
		end else if (sweep_start) begin
			tick_cnt_reg <= record_en ? 7'h00 : tick_cnt_reg + 7'h01;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sweep_reg     <= 1'b0;
			rec_sweep_reg <= 1'b0;
			step_reg      <= 4'h0;
			sig_addr      <= `DTR_RST_SIG;
		end else if (sweep_start) begin
			sweep_reg     <= 1'b1;
			rec_sweep_reg <= state_reg != dtr_pkg::DTR_IDLE && record_en;
			step_reg      <= 4'h0;
			sig_addr      <= trig_src_reg;
		end else if (advance) begin
			sweep_reg <= step_reg != 4'(NUM_CH);
			step_reg  <= step_reg + 4'h1;
			if (step_reg != 4'(NUM_CH)) begin
				sig_addr <= chsel_reg[step_reg + 4'h1];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_val_reg        <= 16'h0000;
			monitor_display_one <= 16'h0000;
			monitor_display_two <= 16'h0000;
		end else if (advance) begin
			case (step_reg)
				4'h0:    trig_val_reg        <= sig_data;
				4'h1:    monitor_display_one <= sig_data;
				4'h2:    monitor_display_two <= sig_data;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Trigger and recording control
	// ----------------------------------------
	logic        fault_pend_reg;
	logic        hit;
	logic [IW:0] count_reg;
	logic [IW-1:0] trig_idx_reg;
	logic [9:0]  post_cnt_reg;
	logic signed [31:0] lhs;
	logic signed [31:0] rhs;

	// Both sides scaled to a common unit so no division is needed
	assign lhs = $signed(trig_val_reg) * `DTR_PCT_SCALE;
	assign rhs = 32'($signed(thresh_reg)) * `DTR_FULL_SCALE;

	always_comb begin
		case (trig_type_reg)
			`DTR_TT_BELOW: hit = lhs < rhs;
			`DTR_TT_EQUAL: hit = lhs == rhs;
			`DTR_TT_ABOVE: hit = lhs > rhs;
			default:       hit = fault_pend_reg;
		endcase
	end

	// A fault in the same cycle as the consume is kept
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fault_pend_reg <= 1'b0;
		end else if (fault_event) begin
			fault_pend_reg <= 1'b1;
		end else if (rec_end || arm_wr) begin
			fault_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg    <= dtr_pkg::DTR_IDLE;
			wp_reg       <= '0;
			count_reg    <= '0;
			trig_idx_reg <= '0;
			post_cnt_reg <= 10'h000;
		end else if (arm_wr) begin
			// A software write beats the self-clear in the same cycle
			state_reg    <= reg_wdata[0] ? dtr_pkg::DTR_PRE : dtr_pkg::DTR_IDLE;
			wp_reg       <= '0;
			count_reg    <= reg_wdata[0] ? '0 : count_reg;
			post_cnt_reg <= 10'h000;
		end else if (rec_end) begin
			wp_reg <= wp_reg + 1'b1;
			if (count_reg != (IW+1)'(DEPTH)) begin
				count_reg <= count_reg + 1'b1;
			end
			case (state_reg)
				dtr_pkg::DTR_PRE: begin
					if (hit) begin
						trig_idx_reg <= wp_reg;
						state_reg    <= dtr_pkg::DTR_POST;
						post_cnt_reg <= 10'h000;
					end
				end
				dtr_pkg::DTR_POST: begin
					if (post_cnt_reg + 10'h001 >= post_reg) begin
						state_reg <= dtr_pkg::DTR_IDLE;
					end else begin
						post_cnt_reg <= post_cnt_reg + 10'h001;
					end
				end
				default: state_reg <= dtr_pkg::DTR_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Buffer path
	// ----------------------------------------
	logic [PW-1:0] pop_data;
	logic          pop_valid;
	logic          pop_ready;
	logic          buf_hit;
	logic [2:0]    rd_ch;
	logic [6:0]    rd_idx;
	logic [15:0]   mem [NUM_CH*DEPTH];

	assign buf_hit   = reg_addr[11:10] == `DTR_BUF_TAG;
	assign rd_ch     = reg_addr[9:7];
	assign rd_idx    = reg_addr[6:0];
	// Read-back owns the array for its cycle; the FIFO absorbs the stall
	assign pop_ready = !(reg_rd && buf_hit);

	dtr_fifo #(
		.WIDTH (PW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   ({3'(step_reg - 4'h1), wp_reg, sig_data}),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_data)
	);

	always_ff @(posedge clock) begin
		if (pop_valid && pop_ready) begin
			mem[pop_data[PW-1:16]] <= pop_data[15:0];
		end
	end

	function automatic logic [15:0] to_pct(input logic [15:0] v);
		logic signed [31:0] p;
		p = $signed(v) * `DTR_PCT_SCALE;
		to_pct = 16'(p >>> `DTR_PCT_SHIFT);
	endfunction : to_pct

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	logic [15:0] rd_word;
	logic [15:0] rd_mux;

	assign rd_word = mem[{rd_ch, rd_idx[IW-1:0]}];

	always_comb begin
		rd_mux = 16'h0000;
		if (buf_hit) begin
			if (rd_idx <= `DTR_IDX_MAX && 32'(rd_idx) < DEPTH) begin
				rd_mux = format_reg ? to_pct(rd_word) : rd_word;
			end
		end else if (chsel_hit) begin
			rd_mux = chsel_idx == 4'h0 ? 16'h0000 : 16'(chsel_reg[chsel_idx]);
		end else begin
			case (reg_addr)
				`DTR_A_VALID:     rd_mux = 16'(count_reg);
				`DTR_A_TRIG_IDX:  rd_mux = 16'(trig_idx_reg);
				`DTR_A_TRIG_SRC:  rd_mux = 16'(trig_src_reg);
				`DTR_A_TRIG_TYPE: rd_mux = 16'(trig_type_reg);
				`DTR_A_THRESH:    rd_mux = 16'($signed(thresh_reg));
				`DTR_A_INTERVAL:  rd_mux = 16'(interval_reg);
				`DTR_A_POST:      rd_mux = 16'(post_reg);
				`DTR_A_ARM:       rd_mux = 16'(state_reg != dtr_pkg::DTR_IDLE);
				`DTR_A_FORMAT:    rd_mux = 16'(format_reg);
				default:          rd_mux = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence tick_idle_s;
		sweep_start && !(rec_sweep_reg && sweep_reg);
	endsequence
	sequence plain_sweep_s;
		tick_idle_s ##1 !rec_sweep_reg;
	endsequence

	sweep_length_a: assert property (plain_sweep_s |-> ##9 !sweep_reg)
		else $error("plain sweep did not end after nine steps");
	src_first_a: assert property (sweep_start |=> sig_addr == $past(trig_src_reg))
		else $error("sweep did not start on trigger source");
	monitor_one_a: assert property (advance && step_reg == 4'h1 |=>
		monitor_display_one == $past(sig_data))
		else $error("monitor one missed channel one value");
	count_cap_a: assert property (count_reg <= (IW+1)'(DEPTH))
		else $error("valid line count above depth");
	idx_limit_a: assert property (reg_rd && buf_hit && rd_idx > `DTR_IDX_MAX |=>
		reg_rdata == 16'h0000)
		else $error("index above 99 read nonzero");
	hex_format_a: assert property (reg_rd && buf_hit && !format_reg && rd_idx <= `DTR_IDX_MAX
		|=> reg_rdata == $past(rd_word))
		else $error("hex read differs from stored word");
	trig_capture_a: assert property (state_reg == dtr_pkg::DTR_PRE && rec_end && hit && !arm_wr
		|=> trig_idx_reg == $past(wp_reg) && state_reg == dtr_pkg::DTR_POST)
		else $error("trigger index not taken from write position");
	wp_wrap_a: assert property (rec_end && !arm_wr && wp_reg == IW'(DEPTH - 1)
		|=> wp_reg == '0)
		else $error("write position did not wrap");
	arm_clear_a: assert property (state_reg == dtr_pkg::DTR_POST && rec_end && !arm_wr &&
		post_cnt_reg + 10'h001 >= post_reg |=> state_reg == dtr_pkg::DTR_IDLE)
		else $error("arm did not clear after post delay");
	divider_a: assert property (tick_cnt_reg < interval_reg)
		else $error("interval divider overran");
endmodule : dtr_recorder

// ---- common/dtr_regs.svh ----
// Register offsets, reset values and fixed codes of the diagnostic trace recorder.
// Assumes word addressing on a 12-bit plain register port.
`ifndef DTR_REGS_SVH
`define DTR_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTR_A_VALID      12'h000
`define DTR_A_TRIG_IDX   12'h001
`define DTR_A_TRIG_SRC   12'h002
`define DTR_A_TRIG_TYPE  12'h003
`define DTR_A_THRESH     12'h004
`define DTR_A_INTERVAL   12'h005
`define DTR_A_POST       12'h006
`define DTR_A_ARM        12'h007
`define DTR_A_FORMAT     12'h008
`define DTR_A_CHSEL      12'h010
`define DTR_A_CHSEL_LAST 12'h018
`define DTR_BUF_TAG      2'h1

// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
`define DTR_RST_INTERVAL 7'h01
`define DTR_MAX_INTERVAL 7'h63
`define DTR_RST_TYPE     2'h0
`define DTR_RST_THRESH   12'h000
`define DTR_RST_SIG      9'h000
`define DTR_RST_POST     10'h001
`define DTR_MAX_POST     10'h3e7
`define DTR_RST_FORMAT   1'b1
`define DTR_IDX_MAX      7'h63

// ----------------------------------------
// Trigger codes and scaling
// ----------------------------------------
`define DTR_TT_BELOW     2'h0
`define DTR_TT_EQUAL     2'h1
`define DTR_TT_ABOVE     2'h2
`define DTR_TT_FAULT     2'h3
`define DTR_PCT_SCALE    32'sh000003e8
`define DTR_FULL_SCALE   32'sh00004000
`define DTR_PCT_SHIFT    14

`endif

// ---- common/dtr_pkg.sv ----
// Types shared by the trace recorder files.
// Assumes nothing of its surroundings.
package dtr_pkg;
	typedef enum logic [1:0] {DTR_IDLE, DTR_PRE, DTR_POST} dtr_state_e;
	typedef logic [15:0] dtr_word_t;
endpackage : dtr_pkg

// ---- design/dtr_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module dtr_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_cfg
		$error("dtr_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
	                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty     = wr_ptr_reg == rd_ptr_reg;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clock) begin
		if (in_valid && !full) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule : dtr_fifo

// ---- test/tb_top.sv ----
// Self-checking bench of the trace recorder: register map, FIFO stalls and four recordings.
// Assumes the recorder alone on one clock; the bench answers signal lookups itself.
`include "dtr_regs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic        clock;
	logic        rst;
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        firing_tick;
	logic        fault_event;
	logic [8:0]  sig_addr;
	logic [15:0] sig_data;
	logic [15:0] sig_base;
	logic [15:0] mon_one;
	logic [15:0] mon_two;
	logic [15:0] m_mem[8][128];
	int          m_sel[9];
	int          m_wp;
	int          m_vc;
	int          m_div;
	int          m_tidx;
	int          m_left;
	int          m_nrec;
	bit          m_armed;
	bit          m_pre;
	bit          m_flt;
	int          fail_count;
	int          comparisons;
	int          seed;
	// Type, threshold, interval, post delay, records before trigger, trigger base
	int          cfg[4][6] = '{'{2, 100, 2, 3, 5, 2000}, '{0, -50, 1, 2, 3, -4096},
	                           '{1, 125, 3, 1, 2, 1908}, '{3, 0, 1, 1, 130, 0}};

	// Lookup answers combinationally; the base only moves when a tick is raised
	assign sig_data = sig_base + 16'(sig_addr) * 16'h0007;

	initial clock = 1'b0;
	always #2 clock = ~clock;

	dtr_recorder #(.NUM_CH(8), .DEPTH(128), .FIFO_DEPTH(4)) dtr_recorder_inst (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.firing_tick(firing_tick), .fault_event(fault_event), .sig_addr(sig_addr),
		.sig_data(sig_data), .monitor_display_one(mon_one), .monitor_display_two(mon_two));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task rchk(input logic [11:0] a, input logic [15:0] exp, input string what);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, what);
	endtask : rchk

	function automatic logic [15:0] fmt(input logic [15:0] w, input int pct);
		int s;
		s = int'($signed(w)) * 1000;
		return pct ? 16'(s >>> 14) : w;
	endfunction : fmt

	// Ticks are spaced well beyond one sweep so none is dropped
	// Back-to-back buffer reads across a sweep hold the FIFO full and stall the sweep
	task tick(input logic [15:0] base, input bit hold);
		@(posedge clock);
		sig_base <= base;
		firing_tick <= 1'b1;
		@(posedge clock);
		firing_tick <= 1'b0;
		reg_rd <= hold;
		reg_addr <= 12'h464;
		for (int c = 0; c < 10; c++) begin
			@(posedge clock);
			if (c == 9) reg_rd <= 1'b0;
			#1 chk(reg_rdata, 16'h0000, "stalled read above 99");
		end
		repeat (16) @(posedge clock);
		#1 chk(mon_one, base + 16'(m_sel[1] * 7), "monitor one");
		chk(mon_two, base + 16'(m_sel[2] * 7), "monitor two");
	endtask : tick

	task m_record(input logic [15:0] b, input int typ, input int th, input int post);
		logic signed [15:0] v;
		bit                 hit;
		for (int k = 0; k < 8; k++) m_mem[k][m_wp] = b + 16'(m_sel[k + 1] * 7);
		v = b + 16'h008c;
		case (typ)
			0: hit = (v * 1000) < (th * 16384);
			1: hit = (v * 1000) == (th * 16384);
			2: hit = (v * 1000) > (th * 16384);
			default: hit = m_flt;
		endcase
		if (m_pre) begin
			if (hit) begin
				m_pre = 0;
				m_tidx = m_wp;
				m_left = post;
			end
		end else begin
			m_left--;
			if (m_left == 0) m_armed = 0;
		end
		m_flt = 0;
		m_wp = (m_wp + 1) % 128;
		if (m_vc < 128) m_vc++;
		m_nrec++;
	endtask : m_record

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task run(input int i);
		int          typ;
		int          th;
		int          iv;
		logic [15:0] b;
		typ = cfg[i][0];
		th = cfg[i][1];
		iv = cfg[i][2];
		for (int k = 1; k < 9; k++) begin
			m_sel[k] = ($random(seed) & 255) + k;
			wr(`DTR_A_CHSEL + 12'(k), 16'(m_sel[k]));
		end
		wr(`DTR_A_TRIG_SRC, 16'h0014);
		wr(`DTR_A_TRIG_TYPE, 16'(typ));
		wr(`DTR_A_THRESH, 16'(th));
		wr(`DTR_A_INTERVAL, 16'(iv));
		wr(`DTR_A_POST, 16'(cfg[i][3]));
		wr(`DTR_A_FORMAT, 16'(i % 2));
		rchk(`DTR_A_THRESH, 16'(th), "threshold");
		rchk(`DTR_A_TRIG_TYPE, 16'(typ), "trigger type");
		rchk(`DTR_A_TRIG_SRC, 16'h0014, "trigger source");
		rchk(`DTR_A_INTERVAL, 16'(iv), "interval");
		rchk(`DTR_A_POST, 16'(cfg[i][3]), "post delay");
		rchk(`DTR_A_FORMAT, 16'(i % 2), "format");
		wr(`DTR_A_ARM, 16'h0001);
		{m_armed, m_pre, m_wp, m_vc, m_div, m_flt, m_nrec} = {1'b1, 1'b1, 32'd0, 32'd0, 32'd0, 1'b0, 32'd0};
		rchk(`DTR_A_ARM, 16'h0001, "arm while recording");
		for (int d = 0; d < 400 && m_armed; d++) begin
			b = 16'($random(seed) & 255);
			if (m_div == iv - 1 && m_pre && m_nrec == cfg[i][4]) begin
				if (typ == 3) begin
					@(posedge clock);
					fault_event <= 1'b1;
					@(posedge clock);
					fault_event <= 1'b0;
					m_flt = 1;
				end else b = 16'(cfg[i][5]);
			end
			tick(b, 1'(d % 2));
			if (m_div == iv - 1) begin
				m_div = 0;
				m_record(b, typ, th, cfg[i][3]);
			end else m_div++;
		end
		rchk(`DTR_A_ARM, 16'h0000, "arm after recording");
		rchk(`DTR_A_VALID, 16'(m_vc), "valid count");
		rchk(`DTR_A_TRIG_IDX, 16'(m_tidx), "trigger index");
		for (int k = 0; k < 8; k++) begin
			for (int x = 0; x < 100 && x < m_vc; x++)
				rchk(12'h400 + 12'(k * 128 + x), fmt(m_mem[k][x], i % 2), "buffer");
			rchk(12'h400 + 12'(k * 128 + 100), 16'h0000, "index above 99");
		end
	endtask : run

	task wrap_up;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial begin
		{rst, reg_addr, reg_wdata, reg_wr, reg_rd, firing_tick, fault_event} = {1'b1, 32'd0};
		{sig_base, fail_count, comparisons, seed} = {16'd0, 64'd0, 32'd54};
		m_sel = '{default: 0};
		m_tidx = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rchk(`DTR_A_VALID, 16'h0000, "reset valid count");
		rchk(`DTR_A_TRIG_IDX, 16'h0000, "reset trigger index");
		rchk(`DTR_A_TRIG_SRC, 16'(`DTR_RST_SIG), "reset source");
		rchk(`DTR_A_TRIG_TYPE, 16'(`DTR_RST_TYPE), "reset type");
		rchk(`DTR_A_THRESH, 16'(`DTR_RST_THRESH), "reset threshold");
		rchk(`DTR_A_INTERVAL, 16'(`DTR_RST_INTERVAL), "reset interval");
		rchk(`DTR_A_ARM, 16'h0000, "reset arm");
		for (int k = 0; k < 9; k++) rchk(`DTR_A_CHSEL + 12'(k), 16'h0000, "reset select");
		wr(`DTR_A_INTERVAL, 16'h0000);
		rchk(`DTR_A_INTERVAL, 16'h0001, "interval floor");
		wr(`DTR_A_INTERVAL, 16'h00c8);
		rchk(`DTR_A_INTERVAL, 16'h0063, "interval ceiling");
		wr(`DTR_A_POST, 16'h0000);
		rchk(`DTR_A_POST, 16'h0001, "post floor");
		wr(`DTR_A_POST, 16'h05dc);
		rchk(`DTR_A_POST, 16'h03e7, "post ceiling");
		wr(`DTR_A_POST, 16'h0400);
		rchk(`DTR_A_POST, 16'h03e7, "post ceiling wide");
		wr(`DTR_A_CHSEL, 16'h0005);
		rchk(`DTR_A_CHSEL, 16'h0000, "reserved select");
		wr(`DTR_A_VALID, 16'h0005);
		rchk(`DTR_A_VALID, 16'h0000, "read-only count");
		rchk(12'h00f, 16'h0000, "unmapped");
		for (int i = 0; i < 4; i++) run(i);
		wrap_up();
	end

	// A hang is cut short well after the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		fail_count++;
		wrap_up();
	end
endmodule : tb_top
